// ==== rtl/tldo_pkg.sv ====
// Constants and types for the transmit line digital output block
package tldo_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] TLDO_OFF_CTRL = 8'h00;
  localparam logic [7:0] TLDO_OFF_STATUS = 8'h04;

  // ==========================================================
  // Control word fields
  localparam int TLDO_CTRL_WIDTH = 12;
  localparam int TLDO_CTRL_EN = 0;
  localparam int TLDO_CTRL_MODE_LSB = 1;
  localparam int TLDO_CTRL_CLK_INV = 4;
  localparam int TLDO_CTRL_DAT_INV = 5;
  localparam int TLDO_CTRL_REF_LSB = 6;
  localparam int TLDO_CTRL_LIU_EN = 9;
  localparam int TLDO_CTRL_POS_DIS = 10;
  localparam int TLDO_CTRL_REF_INV = 11;
  localparam logic [11:0] TLDO_CTRL_RESET = 12'h000;

  // ==========================================================
  // Status word fields
  localparam int TLDO_STAT_LINK_EN = 0;
  localparam int TLDO_STAT_COUNT_LSB = 8;
  localparam int TLDO_COUNT_WIDTH = 8;

  // ==========================================================
  // Line modes and reference clock choices
  localparam logic [2:0] TLDO_MODE_AMI = 3'h0;
  localparam logic [2:0] TLDO_MODE_B3ZS = 3'h1;
  localparam logic [2:0] TLDO_MODE_HDB3 = 3'h2;
  localparam int TLDO_MODE_UNI_BIT = 2;
  localparam logic [2:0] TLDO_REF_LINE = 3'h0;
  localparam logic [2:0] TLDO_REF_TX_OUT = 3'h1;
  localparam logic [2:0] TLDO_REF_TX_IN = 3'h2;
  localparam logic [2:0] TLDO_REF_RX_LINE = 3'h3;
  localparam logic [2:0] TLDO_REF_RX_OUT = 3'h4;

  // ==========================================================
  // Coder pipeline and helper timing
  localparam int TLDO_PIPE_DEPTH = 4;
  localparam int TLDO_FRAME_DELAY = 4;
  localparam logic [3:0] TLDO_STEADY_MAX = 4'hF;

  typedef enum logic [1:0] {
    TLDO_SYM_ZERO = 2'h0,
    TLDO_SYM_MARK = 2'h1,
    TLDO_SYM_BIPOLAR = 2'h2,
    TLDO_SYM_VIOL = 2'h3
  } tldo_sym_t;

endpackage

// ==== rtl/tldo_sync.sv ====
// Two flip-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
module tldo_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // ==========================================================
  // Per-bit chains; first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end

endmodule

// ==== rtl/tldo_line_coder.sv ====
// AMI, B3ZS, HDB3 and unipolar line coder on the link clock
`timescale 1ns/1ps
module tldo_line_coder (
  input wire logic linkClk,
  input wire logic rst_b,
  input wire logic bitIn,
  input wire logic [2:0] mode,
  output logic posCode,
  output logic negCode,
  output logic substToggle
);
  import tldo_pkg::*;

  tldo_sym_t slot [TLDO_PIPE_DEPTH];
  tldo_sym_t incoming;
  logic onesOdd;
  logic lastPol;
  logic unipolar_mode;
  logic hdbHit;
  logic bzsHit;

  // ==========================================================
  // Zero run detection on the incoming bit plus stored zeros
  always_comb begin
    unipolar_mode = mode[TLDO_MODE_UNI_BIT];
    hdbHit = !unipolar_mode && (mode == TLDO_MODE_HDB3) && !bitIn && (slot[0] == TLDO_SYM_ZERO)
      && (slot[1] == TLDO_SYM_ZERO) && (slot[2] == TLDO_SYM_ZERO);
    bzsHit = !unipolar_mode && (mode == TLDO_MODE_B3ZS) && !bitIn && (slot[0] == TLDO_SYM_ZERO)
      && (slot[1] == TLDO_SYM_ZERO);
    if (hdbHit || bzsHit) begin
      incoming = TLDO_SYM_VIOL;
    end else if (bitIn) begin
      incoming = TLDO_SYM_MARK;
    end else begin
      incoming = TLDO_SYM_ZERO;
    end
  end

  // ==========================================================
  // Symbol pipeline; even pulse count needs a leading B pulse
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < TLDO_PIPE_DEPTH; i++) begin
        slot[i] <= TLDO_SYM_ZERO;
      end
    end else begin
      slot[0] <= incoming;
      slot[1] <= slot[0];
      slot[2] <= (bzsHit && !onesOdd) ? TLDO_SYM_BIPOLAR : slot[1];
      slot[3] <= (hdbHit && !onesOdd) ? TLDO_SYM_BIPOLAR : slot[2];
    end
  end

  // Pulses since the last violation, counted at insertion
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      onesOdd <= 1'b0;
      substToggle <= 1'b0;
    end else if (hdbHit || bzsHit) begin
      onesOdd <= 1'b0;
      substToggle <= !substToggle;
    end else if (bitIn) begin
      onesOdd <= !onesOdd;
    end
  end

  // ==========================================================
  // Polarity: marks alternate, violations repeat the last pulse
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      posCode <= 1'b0;
      negCode <= 1'b0;
      lastPol <= 1'b0;
    end else if (unipolar_mode) begin
      posCode <= (slot[3] != TLDO_SYM_ZERO);
      negCode <= 1'b0;
    end else begin
      case (slot[3])
        TLDO_SYM_MARK, TLDO_SYM_BIPOLAR: begin
          posCode <= !lastPol;
          negCode <= lastPol;
          lastPol <= !lastPol;
        end
        TLDO_SYM_VIOL: begin
          posCode <= lastPol;
          negCode <= !lastPol;
        end
        default: begin
          posCode <= 1'b0;
          negCode <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== rtl/tldo_top.sv ====
// Transmit line digital output stage with APB control
// How it works
// - Line clock output toggles only while line pins are enabled, at line rate.
// - The line clock can also time serial data and frame signals.
// - Coded modes drive positive pulse high for each positive line pulse.
// - Data change on rising reference edge, or falling edge when inverted.
// - Reference defaults to line clock; four other clocks selectable.
// - Unipolar mode puts the raw bit stream on the shared output.
// - With the line interface unit on, positive output may be disabled.
// - Line clock and positive or data output polarity are invertible.
// - Coded modes drive negative pulse high for each negative line pulse.
// - Mode codes with top bit set select unipolar; pins must be enabled.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tldo_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txLineClk,
  input wire logic txClockOut,
  input wire logic txClockIn,
  input wire logic rxLineClockIn,
  input wire logic rxClockOut,
  input wire logic txSerialIn,
  input wire logic txFrameStartIn,
  output logic txLineClockOut,
  output logic txPositivePulse,
  output logic txNegativePulse,
  output logic txFrameStartOut,
  output logic txDataValidOut
);
  import tldo_pkg::*;

  logic [tldo_pkg::TLDO_CTRL_WIDTH-1:0] portControlTwo;
  logic [31:0] readValue;
  logic mapped;
  logic setup;
  logic accessDone;
  logic [1:0] backSync;
  logic togglePrev;
  logic [tldo_pkg::TLDO_COUNT_WIDTH-1:0] substCount;
  logic refMux;
  logic edgeInv;
  logic linkClk;
  logic [tldo_pkg::TLDO_CTRL_WIDTH-1:0] cfgLink;
  logic [tldo_pkg::TLDO_CTRL_WIDTH-1:0] cfgPrev;
  logic [tldo_pkg::TLDO_CTRL_WIDTH-1:0] cfgApplied;
  logic [3:0] steadyCnt;
  logic enL;
  logic uniL;
  logic datInvL;
  logic posDisL;
  logic [2:0] modeL;
  logic posCode;
  logic negCode;
  logic substToggle;
  logic [tldo_pkg::TLDO_FRAME_DELAY-1:0] frameDly;
  logic [2:0] zeroRun;

  // ==========================================================
  // APB slave: one wait-free access, registered answer
  always_comb begin
    setup = psel && !penable;
    accessDone = psel && penable && pready;
    mapped = 1'b0;
    readValue = 32'h00000000;
    if (paddr == TLDO_OFF_CTRL) begin
      mapped = 1'b1;
      readValue[TLDO_CTRL_WIDTH-1:0] = portControlTwo;
    end else if (paddr == TLDO_OFF_STATUS) begin
      mapped = 1'b1;
      readValue[TLDO_STAT_LINK_EN] = backSync[0];
      readValue[TLDO_STAT_COUNT_LSB +: TLDO_COUNT_WIDTH] = substCount;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? readValue : 32'h00000000;
    end
  end

  // Writes land at the access edge; status is read only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portControlTwo <= TLDO_CTRL_RESET;
    end else if (accessDone && pwrite && (paddr == TLDO_OFF_CTRL)) begin
      portControlTwo <= pwdata[TLDO_CTRL_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Link state back to the bus clock
  tldo_sync #(.W(2)) u_back_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({substToggle, enL}),
    .q(backSync)
  );

  // Each toggle edge is one zero substitution
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      togglePrev <= 1'b0;
      substCount <= '0;
    end else begin
      togglePrev <= backSync[1];
      if (togglePrev != backSync[1]) begin
        substCount <= substCount + 1'b1;
      end
    end
  end

  // ==========================================================
  // Reference clock choice and line clock output
  // Select and invert are static settings; change them only with pins off
  // reference clock select
  always_comb begin
    if (portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_TX_OUT) begin
      refMux = txClockOut;
    end else if (portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_TX_IN) begin
      refMux = txClockIn;
    end else if (portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_RX_LINE) begin
      refMux = rxLineClockIn;
    end else if (portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_RX_OUT) begin
      refMux = rxClockOut;
    end else begin
      refMux = txLineClk;
    end
    // inverted reference moves the launch edge
    if (portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_TX_OUT
        || portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_TX_IN
        || portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_RX_LINE
        || portControlTwo[TLDO_CTRL_REF_LSB +: 3] == TLDO_REF_RX_OUT) begin
      edgeInv = portControlTwo[TLDO_CTRL_REF_INV];
    end else begin
      edgeInv = portControlTwo[TLDO_CTRL_CLK_INV];
    end
  end

  assign linkClk = refMux ^ edgeInv;

  // clock polarity
  // Clock path cannot be a flop; gate follows the enable bit directly
  assign txLineClockOut = portControlTwo[TLDO_CTRL_EN]
    && (txLineClk ^ portControlTwo[TLDO_CTRL_CLK_INV]);

  // ==========================================================
  // Link domain: settings cross in, coder, output flops
  tldo_sync #(.W(TLDO_CTRL_WIDTH)) u_cfg_sync (
    .clk(linkClk),
    .rst_b(rst_b),
    .d(portControlTwo),
    .q(cfgLink)
  );

  always_comb begin
    enL = cfgApplied[TLDO_CTRL_EN];
    modeL = cfgApplied[TLDO_CTRL_MODE_LSB +: 3];
    uniL = modeL[TLDO_MODE_UNI_BIT];
    datInvL = cfgApplied[TLDO_CTRL_DAT_INV];
    posDisL = cfgApplied[TLDO_CTRL_LIU_EN] && cfgApplied[TLDO_CTRL_POS_DIS];
  end

  // Bits may land a cycle apart; steadiness counter spans that
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      cfgPrev <= TLDO_CTRL_RESET;
      steadyCnt <= 4'h0;
    end else begin
      cfgPrev <= cfgLink;
      if (cfgPrev != cfgLink) begin
        steadyCnt <= 4'h0;
      end else if (steadyCnt != TLDO_STEADY_MAX) begin
        steadyCnt <= steadyCnt + 4'h1;
      end
    end
  end

  // Two equal samples in a row; a half-landed word is never applied
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      cfgApplied <= TLDO_CTRL_RESET;
    end else if (cfgPrev == cfgLink) begin
      cfgApplied <= cfgLink;
    end
  end

  // serial data taken on the reference edge
  tldo_line_coder u_coder (
    .linkClk(linkClk),
    .rst_b(rst_b),
    .bitIn(txSerialIn),
    .mode(modeL),
    .posCode(posCode),
    .negCode(negCode),
    .substToggle(substToggle)
  );

  // unipolar data shares the positive pin
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      txPositivePulse <= 1'b0;
    end else if (!enL || posDisL) begin
      txPositivePulse <= 1'b0;
    end else begin
      txPositivePulse <= posCode ^ datInvL;
    end
  end

  // coder gives one polarity per symbol
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      txNegativePulse <= 1'b0;
    end else if (!enL || uniL) begin
      txNegativePulse <= 1'b0;
    end else begin
      txNegativePulse <= negCode ^ datInvL;
    end
  end

  // frame start delayed five link cycles, one fewer than the data path
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      frameDly <= '0;
      txFrameStartOut <= 1'b0;
      txDataValidOut <= 1'b0;
    end else begin
      frameDly <= {frameDly[TLDO_FRAME_DELAY-2:0], txFrameStartIn};
      txFrameStartOut <= enL && frameDly[TLDO_FRAME_DELAY-1];
      txDataValidOut <= enL;
    end
  end

  // Checking helper: consecutive empty bit periods after settling
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      zeroRun <= 3'h0;
    end else if (steadyCnt != TLDO_STEADY_MAX || posCode || negCode) begin
      zeroRun <= 3'h0;
    end else if (zeroRun != 3'h7) begin
      zeroRun <= zeroRun + 3'h1;
    end
  end

  // ==========================================================
  // Assertions
  a_clock_gated: assert property (@(posedge clk) disable iff (!rst_b)
    !portControlTwo[TLDO_CTRL_EN] |-> !txLineClockOut)
    else $error("line clock output active while pins disabled");

  a_disabled_quiet: assert property (@(posedge linkClk) disable iff (!rst_b)
    !enL |=> !txPositivePulse && !txNegativePulse && !txFrameStartOut)
    else $error("line outputs active while pins disabled");

  a_ami_pulse_per_one: assert property (@(posedge linkClk) disable iff (!rst_b)
    (steadyCnt == TLDO_STEADY_MAX && modeL == TLDO_MODE_AMI)
      |-> ((posCode || negCode) == $past(txSerialIn, 5)))
    else $error("AMI pulse does not match the input bit");

  a_pulse_exclusive: assert property (@(posedge linkClk) disable iff (!rst_b)
    !(posCode && negCode))
    else $error("positive and negative pulse in one bit period");

  a_unipolar_data: assert property (@(posedge linkClk) disable iff (!rst_b)
    (steadyCnt == TLDO_STEADY_MAX && uniL && enL && !posDisL)
      |-> (txPositivePulse == ($past(txSerialIn, 6) ^ datInvL)) && !txNegativePulse)
    else $error("unipolar data output does not follow the input");

  a_pos_disable: assert property (@(posedge linkClk) disable iff (!rst_b)
    posDisL |=> !txPositivePulse)
    else $error("positive output driven while disabled");

  a_hdb3_zero_run: assert property (@(posedge linkClk) disable iff (!rst_b)
    (steadyCnt == TLDO_STEADY_MAX && modeL == TLDO_MODE_HDB3) |-> zeroRun <= 3'h3)
    else $error("HDB3 output has four empty bit periods");

  a_b3zs_zero_run: assert property (@(posedge linkClk) disable iff (!rst_b)
    (steadyCnt == TLDO_STEADY_MAX && modeL == TLDO_MODE_B3ZS) |-> zeroRun <= 3'h2)
    else $error("B3ZS output has three empty bit periods");

  a_neg_invert: assert property (@(posedge linkClk) disable iff (!rst_b)
    (enL && !uniL && $stable(datInvL))
      |=> (txNegativePulse == ($past(negCode) ^ $past(datInvL))))
    else $error("negative output polarity wrong");

  a_apb_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
    (setup && !mapped) |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_apb_write: assert property (@(posedge clk) disable iff (!rst_b)
    (setup && pwrite && paddr == TLDO_OFF_CTRL) ##1 accessDone
      |=> portControlTwo == $past(pwdata[TLDO_CTRL_WIDTH-1:0], 2))
    else $error("control write not stored");

  c_unipolar_run: cover property (@(posedge linkClk) disable iff (!rst_b)
    steadyCnt == TLDO_STEADY_MAX && uniL && enL && txPositivePulse);
  c_hdb3_subst: cover property (@(posedge linkClk) disable iff (!rst_b)
    modeL == TLDO_MODE_HDB3 && enL ##1 $changed(substToggle));
  c_b3zs_subst: cover property (@(posedge linkClk) disable iff (!rst_b)
    modeL == TLDO_MODE_B3ZS && enL ##1 $changed(substToggle));
  c_apb_error: cover property (@(posedge clk) disable iff (!rst_b)
    accessDone && pslverr);

endmodule

// ==== verif/tldo_line_partner.sv ====
// Line interface model that receives the coded transmit pulses
`timescale 1ns/1ps
module tldo_line_partner (
  input wire logic rst_b,
  input wire logic lineClk,
  input wire logic posPulse,
  input wire logic negPulse,
  input wire logic checkEdges,
  output logic [15:0] posCount,
  output logic [15:0] negCount,
  output logic [15:0] bothCount,
  output logic [15:0] edgeErrors
);
  realtime lastRise;
  initial begin
    posCount = 16'h0000;
    negCount = 16'h0000;
    bothCount = 16'h0000;
    edgeErrors = 16'h0000;
    lastRise = 0.0;
  end
  // ==========================================================
  // Sampling
  // Mid-bit sampling keeps clear of the update edge
  always @(posedge lineClk) begin
    lastRise = $realtime;
  end
  always @(negedge lineClk) begin
    if (rst_b) begin
      posCount = posCount + {15'h0000, posPulse};
      negCount = negCount + {15'h0000, negPulse};
      bothCount = bothCount + {15'h0000, posPulse & negPulse};
    end
  end
  always @(posPulse or negPulse) begin
    if (checkEdges && rst_b && lastRise != $realtime) begin
      edgeErrors = edgeErrors + 16'h0001;
    end
  end
endmodule

// ==== verif/transmit_line_digital_output_test.sv ====
// Self-checking bench for the transmit line digital output stage
`timescale 1ns/1ps
module transmit_line_digital_output_test;
  import tldo_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, txLineClk, altClk, txSerialIn, txFrameStartIn;
  logic txClockOut, txClockIn, rxLineClockIn, rxClockOut, checkEdges;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] refSel;
  logic pready, pslverr, txLineClockOut, txPositivePulse, txNegativePulse;
  logic txFrameStartOut, txDataValidOut;
  logic [15:0] posCount, negCount, bothCount, edgeErrors;
  int failures, compares;
  // ==========================================================
  // Clocks and wiring
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Odd phase keeps link edges off the bus clock edges
  initial begin
    txLineClk = 1'b0;
    #3.3;
    forever #62.5 txLineClk = ~txLineClk;
  end
  assign #40 altClk = txLineClk;
  assign txClockOut = altClk & (refSel == 3'h1);
  assign txClockIn = altClk & (refSel == 3'h2);
  assign rxLineClockIn = altClk & (refSel == 3'h3);
  assign rxClockOut = altClk & (refSel == 3'h4);
  tldo_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txLineClk(txLineClk), .txClockOut(txClockOut), .txClockIn(txClockIn),
    .rxLineClockIn(rxLineClockIn), .rxClockOut(rxClockOut), .txSerialIn(txSerialIn),
    .txFrameStartIn(txFrameStartIn), .txLineClockOut(txLineClockOut),
    .txPositivePulse(txPositivePulse), .txNegativePulse(txNegativePulse),
    .txFrameStartOut(txFrameStartOut), .txDataValidOut(txDataValidOut));
  tldo_line_partner partner (.rst_b(rst_b), .lineClk(txLineClockOut),
    .posPulse(txPositivePulse), .negPulse(txNegativePulse), .checkEdges(checkEdges),
    .posCount(posCount), .negCount(negCount), .bothCount(bothCount), .edgeErrors(edgeErrors));
  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    check("wait states", n, 32'd0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apbXfer(1'b1, a, d, r, e);
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d, output logic e);
    apbXfer(1'b0, a, 32'h00000000, d, e);
  endtask
  task automatic setCtrl(input logic [11:0] v);
    wrReg(TLDO_OFF_CTRL, {20'h00000, v});
  endtask
  function automatic logic [11:0] mk(input logic [2:0] m, input logic [11:0] ex);
    return ex | (12'h001 << TLDO_CTRL_EN) | ({9'h000, m} << TLDO_CTRL_MODE_LSB);
  endfunction
  task automatic linkWait(input int n);
    repeat (n) @(posedge txLineClk);
    #1;
  endtask
  task automatic drive(input logic b);
    @(posedge clk);
    txSerialIn <= b;
  endtask
  // ==========================================================
  // Scenarios
  task automatic testRegs();
    logic [31:0] d;
    logic e;
    rdReg(TLDO_OFF_CTRL, d, e);
    check("ctrl reset", d, {20'h00000, TLDO_CTRL_RESET});
    wrReg(TLDO_OFF_STATUS, 32'hFFFFFFFF);
    rdReg(TLDO_OFF_STATUS, d, e);
    check("status ro", d, 32'h00000000);
    rdReg(8'h08, d, e);
    check("unmapped err", e, 1'b1);
    wrReg(TLDO_OFF_CTRL, 32'hFFFFFFFE);
    rdReg(TLDO_OFF_CTRL, d, e);
    check("ctrl rw", d, 32'h00000FFE);
    repeat (4) begin
      @(negedge txLineClk);
      check("clk off", txLineClockOut, 1'b0);
    end
    setCtrl(12'h000);
    $display("done registers");
  endtask
  task automatic testModes();
    logic [15:0] p0, n0, b0;
    logic [31:0] d;
    logic e;
    drive(1'b1);
    for (int m = 0; m < 8; m++) begin
      setCtrl(mk(3'(m), 12'h000));
      linkWait(20);
      checkEdges = 1'b1;
      p0 = posCount;
      n0 = negCount;
      b0 = bothCount;
      linkWait(16);
      check("pos pulses", posCount - p0, (m >= 4) ? 32'd16 : 32'd8);
      check("neg pulses", negCount - n0, (m >= 4) ? 32'd0 : 32'd8);
      check("both high", bothCount - b0, 32'd0);
    end
    rdReg(TLDO_OFF_STATUS, d, e);
    check("link echo", d[0], 1'b1);
    $display("done modes");
  endtask
  task automatic testZeros();
    logic [2:0] md [3] = '{TLDO_MODE_AMI, TLDO_MODE_B3ZS, TLDO_MODE_HDB3};
    int mins [3] = '{0, 7, 5};
    logic [31:0] d0, d1;
    logic e;
    logic [15:0] t0, tot;
    logic [7:0] sub;
    drive(1'b0);
    for (int i = 0; i < 3; i++) begin
      setCtrl(mk(md[i], 12'h000));
      linkWait(16);
      rdReg(TLDO_OFF_STATUS, d0, e);
      t0 = posCount + negCount;
      linkWait(24);
      rdReg(TLDO_OFF_STATUS, d1, e);
      tot = posCount + negCount - t0;
      sub = d1[15:8] - d0[15:8];
      if (i == 0) begin
        check("ami zeros", tot, 16'h0000);
        check("ami subst", sub, 8'h00);
      end else begin
        check("coded pulses", tot >= mins[i], 1'b1);
        check("subst count", sub >= mins[i], 1'b1);
      end
    end
    check("edge errors", edgeErrors, 16'h0000);
    check("both total", bothCount, 16'h0000);
    checkEdges = 1'b0;
    $display("done zeros");
  endtask
  task automatic testInvert();
    logic [11:0] inv;
    inv = (12'h001 << TLDO_CTRL_CLK_INV) | (12'h001 << TLDO_CTRL_DAT_INV);
    setCtrl(12'h000);
    setCtrl(inv);
    drive(1'b1);
    setCtrl(mk(3'h4, inv));
    linkWait(20);
    check("clk inv lo", txLineClockOut, 1'b0);
    @(negedge txLineClk);
    #1;
    check("clk inv hi", txLineClockOut, 1'b1);
    check("data inv one", txPositivePulse, 1'b0);
    drive(1'b0);
    linkWait(20);
    check("data inv zero", txPositivePulse, 1'b1);
    check("neg unipolar", txNegativePulse, 1'b0);
    setCtrl(inv);
    linkWait(6);
    check("pins off clk", txLineClockOut, 1'b0);
    check("pins off data", txPositivePulse, 1'b0);
    setCtrl(12'h000);
    $display("done invert");
  endtask
  task automatic testDisable();
    logic [11:0] ex [3];
    logic xp [3] = '{1'b1, 1'b0, 1'b1};
    ex[0] = 12'h001 << TLDO_CTRL_POS_DIS;
    ex[1] = ex[0] | (12'h001 << TLDO_CTRL_LIU_EN);
    ex[2] = 12'h001 << TLDO_CTRL_LIU_EN;
    drive(1'b1);
    for (int i = 0; i < 3; i++) begin
      setCtrl(mk(3'h4, ex[i]));
      linkWait(10);
      check("pos disable", txPositivePulse, xp[i]);
    end
    setCtrl(12'h000);
    $display("done disable");
  endtask
  task automatic testRefSel();
    for (int r = 1; r < 5; r++) begin
      setCtrl(12'h000);
      refSel <= 3'(r);
      setCtrl((12'(r) << TLDO_CTRL_REF_LSB) | (12'(r == 4) << TLDO_CTRL_REF_INV));
      setCtrl(mk(3'h4, (12'(r) << TLDO_CTRL_REF_LSB) | (12'(r == 4) << TLDO_CTRL_REF_INV)));
      for (int b = 0; b < 2; b++) begin
        drive(b[0]);
        linkWait(20);
        check("ref data", txPositivePulse, b[0]);
      end
    end
    setCtrl(12'h000);
    refSel <= 3'h0;
    $display("done reference");
  endtask
  task automatic testFrame();
    int k;
    k = 1;
    setCtrl(mk(3'h4, 12'h000));
    linkWait(10);
    check("data valid on", txDataValidOut, 1'b1);
    @(negedge txLineClk);
    txFrameStartIn <= 1'b1;
    @(negedge txLineClk);
    txFrameStartIn <= 1'b0;
    while (txFrameStartOut !== 1'b1 && k < 20) begin
      linkWait(1);
      k++;
    end
    check("frame delay", k, TLDO_FRAME_DELAY + 1);
    setCtrl(12'h000);
    linkWait(6);
    check("data valid off", txDataValidOut, 1'b0);
    $display("done frame");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    failures = 0;
    compares = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    txSerialIn = 1'b0;
    txFrameStartIn = 1'b0;
    refSel = 3'h0;
    checkEdges = 1'b0;
    // Held over link edges too, so both domains clear
    repeat (3) @(posedge txLineClk);
    @(posedge clk);
    rst_b <= 1'b1;
    testRegs();
    testModes();
    testZeros();
    testInvert();
    testDisable();
    testRefSel();
    testFrame();
    give_verdict();
  end
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
endmodule
